// ==== design/e1_status_pkg.sv ====
`default_nettype none
package e1_status_pkg;

    // ==================================================================
    // register offsets
    localparam logic [7:0] OFS_STATUS_REG_ONE      = 8'h06;
    localparam logic [7:0] OFS_STATUS_REG_TWO      = 8'h07;
    localparam logic [7:0] OFS_RECEIVE_INFORMATION = 8'h08;
    localparam logic [7:0] OFS_COMMON_CONTROL_ONE  = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK_ONE        = 8'h16;
    localparam logic [7:0] OFS_IRQ_MASK_TWO        = 8'h17;
    localparam logic [7:0] OFS_SYNCHRONIZER_STATUS = 8'h1e;
    localparam logic [7:0] OFS_RX_CHAN_MONITOR_DATA = 8'h2c;
    localparam logic [7:0] OFS_COMMON_CONTROL_FIVE = 8'haa;

    // ==================================================================
    // field positions
    localparam int CTRL5_LINE_IF_RESET_BIT = 7;
    localparam int CTRL5_SEL_MSB           = 4;
    localparam int CTRL5_SEL_LSB           = 0;
    localparam int CTRL1_CRC4_EN_BIT       = 0;
    localparam int SYNC_FAS_SEARCH_BIT     = 2;
    localparam int SYNC_CAS_SEARCH_BIT     = 1;
    localparam int SYNC_CRC_SEARCH_BIT     = 0;
    localparam int RX_INFO_TX_STORE_FULL   = 7;
    localparam int RX_INFO_TX_STORE_EMPTY  = 6;
    localparam int RX_INFO_JITTER_LIMIT    = 5;
    localparam int RX_INFO_RX_STORE_FULL   = 4;
    localparam int RX_INFO_RX_STORE_EMPTY  = 3;
    localparam int RX_INFO_CRC_RESYNC      = 2;
    localparam int RX_INFO_FAS_RESYNC      = 1;
    localparam int RX_INFO_CAS_RESYNC      = 0;
    localparam int CRC_SYNC_COUNT_WIDTH    = 6;

    // status one: bits held while present, bits with change irq
    localparam logic [7:0] SR1_PERSIST_MASK = 8'hef;
    localparam logic [7:0] SR1_CHANGE_MASK  = 8'h0f;
    localparam logic [7:0] NO_BITS_MASK     = 8'h00;

    // ==================================================================
    // reset values
    localparam logic [7:0] CTRL5_RESET     = 8'h00;
    localparam logic [7:0] CTRL1_RESET     = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET  = 8'h00;
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [7:0] MON_DATA_RESET  = 8'h00;

    // ==================================================================
    // timing
    localparam longint CLK_HZ              = 50_000_000;
    localparam longint LINE_IF_RECOVER_MS  = 40;
    localparam longint CRC_SEARCH_MS       = 8;
    localparam int LINE_IF_RECOVER_CYCLES  =
        int'(LINE_IF_RECOVER_MS * CLK_HZ / 1000);
    localparam int CRC_SEARCH_CYCLES       =
        int'(CRC_SEARCH_MS * CLK_HZ / 1000);

    // ==================================================================
    // types
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    typedef enum logic [1:0] {
        LI_IDLE    = 2'b01,
        LI_RECOVER = 2'b10
    } line_if_state_t;

endpackage : e1_status_pkg
`default_nettype wire

// ==== design/status_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
module status_latch #(
    parameter int         WIDTH        = 8,
    parameter logic [7:0] PERSIST_MASK = 8'h00,
    parameter logic [7:0] CHANGE_MASK  = 8'h00
) (
    input  wire logic             mclk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic [WIDTH-1:0] level_in,
    input  wire logic             mask_wr_in,
    input  wire logic             rd_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    output logic      [WIDTH-1:0] view_out,
    output logic      [WIDTH-1:0] pend_out
);
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] change;
    logic [WIDTH-1:0] clear;
    logic [WIDTH-1:0] pend_set;
    logic [WIDTH-1:0] persist;
    logic [WIDTH-1:0] chg_mask;

    assign persist  = PERSIST_MASK[WIDTH-1:0];
    assign chg_mask = CHANGE_MASK[WIDTH-1:0];
    assign rise     = level_in & ~level_q;
    assign change   = (level_in ^ level_q) & chg_mask;
    assign clear    = rd_in ? view_out : '0;
    // set wins over a read clear
    assign latch_d  = (latch_q & ~clear) | event_in
                    | (level_in & persist) | change;
    assign pend_set = event_in | (rise & persist & ~chg_mask)
                    | change;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_q <= '0;
        end else begin
            level_q <= level_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            latch_q <= '0;
        end else begin
            latch_q <= latch_d;
        end
    end

    // ==================================================================
    // mask write refreshes the readable copy
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            view_out <= '0;
        end else if (mask_wr_in) begin
            view_out <= (view_out & ~wdata_in) | (latch_q & wdata_in);
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_out <= '0;
        end else begin
            pend_out <= (pend_out & ~clear) | pend_set;
        end
    end

endmodule // status_latch
`default_nettype wire

// ==== design/e1_status_latch_and_irq.sv ====
// Summary of operation
// - rising edge of line-interface reset bit starts a clock recovery reset.
// - line interface needs about forty milliseconds to recover after it.
// - control five bits four to zero select the monitored receive channel.
// - status and information bits latch on event until read.
// - read clears a bit; listed alarm bits stay set while present.
// - write acts as mask: ones refresh readable copy, zeros hold it.
// - synchronizer status is read-only, unlatched, real time.
// - each status bit can raise interrupt, gated by its mask bit.
// - four level alarms interrupt on both activation and release.
// - alarm interrupt releases once host reads the causing bit.
// - status one and two event sources interrupt on event, release when their bit is read.
// - info bits seven and six flag transmit store full and empty slips.
// - info bits four and three flag receive store full and empty slips.
// - info bit five flags jitter fifo within four bits of limit.
// - info bit two flags 915 of 1000 crc4 words in error.
// - info bit one flags three consecutive bad frame alignment words.
// - info bit zero flags two consecutive bad cas alignment words.
// - sync bits two to zero show frame, cas and crc4 searching.
// - sync bits 7..4 show counter bits 5..2; bit 3 shows counter bit 0.
// - crc4 sync counter counts 8 ms search timeouts and wraps.
// - counter clears on crc4 sync or while crc4 mode is disabled.
// - status one bit zero set while not synchronized to receive stream.
`timescale 1ns/1ps
`default_nettype none
module e1_status_latch_and_irq
    import e1_status_pkg::*;
#(
    parameter int RECOVER_CYCLES    = LINE_IF_RECOVER_CYCLES,
    parameter int CRC_SEARCH_LENGTH = CRC_SEARCH_CYCLES
) (
    input  wire logic       mclk_in,
    input  wire logic       rstn_in,
    // host port, same clock
    input  wire host_req_t  host_req_in,
    output logic [7:0]      rdata_out,
    output logic            int_n_out,
    // status one sources
    input  wire logic [7:0] status_one_level_in,
    input  wire logic [7:0] status_one_event_in,
    // status two and receive information sources
    input  wire logic [7:0] status_two_event_in,
    input  wire logic [7:0] rx_info_event_in,
    // synchronizer state
    input  wire logic       frame_align_searching_in,
    input  wire logic       cas_mf_searching_in,
    input  wire logic       crc_mf_searching_in,
    input  wire logic       crc_sync_achieved_in,
    // receive channel data stream
    input  wire logic       rx_chan_valid_in,
    input  wire logic [4:0] rx_chan_num_in,
    input  wire logic [7:0] rx_chan_byte_in,
    // line interface control
    output logic            line_if_reset_out,
    output logic            line_if_recovering_out,
    output logic            crc_mode_en_out,
    output logic [4:0]      rx_chan_monitor_sel_out
);

    // ==================================================================
    // address decode
    function automatic logic hit(input host_req_t req,
                                 input logic [7:0] ofs);
        hit = req.addr == ofs;
    endfunction

    logic wr_ctrl5;
    logic wr_ctrl1;
    logic wr_mask1;
    logic wr_mask2;
    logic wr_sr1;
    logic wr_sr2;
    logic wr_rir;
    logic rd_sr1;
    logic rd_sr2;
    logic rd_rir;

    assign wr_ctrl5 = host_req_in.wr && hit(host_req_in,
        OFS_COMMON_CONTROL_FIVE);
    assign wr_ctrl1 = host_req_in.wr && hit(host_req_in,
        OFS_COMMON_CONTROL_ONE);
    assign wr_mask1 = host_req_in.wr && hit(host_req_in, OFS_IRQ_MASK_ONE);
    assign wr_mask2 = host_req_in.wr && hit(host_req_in, OFS_IRQ_MASK_TWO);
    assign wr_sr1   = host_req_in.wr && hit(host_req_in, OFS_STATUS_REG_ONE);
    assign wr_sr2   = host_req_in.wr && hit(host_req_in, OFS_STATUS_REG_TWO);
    assign wr_rir   = host_req_in.wr && hit(host_req_in,
        OFS_RECEIVE_INFORMATION);
    assign rd_sr1   = host_req_in.rd && hit(host_req_in, OFS_STATUS_REG_ONE);
    assign rd_sr2   = host_req_in.rd && hit(host_req_in, OFS_STATUS_REG_TWO);
    assign rd_rir   = host_req_in.rd && hit(host_req_in,
        OFS_RECEIVE_INFORMATION);

    // ==================================================================
    // control registers
    logic [7:0] common_control_five_q;
    logic [7:0] common_control_one_q;
    logic [7:0] irq_mask_one_q;
    logic [7:0] irq_mask_two_q;

    // bits six and five kept as written
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            common_control_five_q <= CTRL5_RESET;
        end else if (wr_ctrl5) begin
            common_control_five_q <= host_req_in.wdata;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            common_control_one_q <= CTRL1_RESET;
        end else if (wr_ctrl1) begin
            common_control_one_q <= host_req_in.wdata;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            irq_mask_one_q <= IRQ_MASK_RESET;
            irq_mask_two_q <= IRQ_MASK_RESET;
        end else begin
            if (wr_mask1) begin
                irq_mask_one_q <= host_req_in.wdata;
            end
            if (wr_mask2) begin
                irq_mask_two_q <= host_req_in.wdata;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            crc_mode_en_out         <= 1'b0;
            rx_chan_monitor_sel_out <= 5'h00;
        end else begin
            crc_mode_en_out <= common_control_one_q[CTRL1_CRC4_EN_BIT];
            rx_chan_monitor_sel_out <=
                common_control_five_q[CTRL5_SEL_MSB:CTRL5_SEL_LSB];
        end
    end

    // ==================================================================
    // line interface reset and recovery
    line_if_state_t li_state_q;
    logic           li_bit_q;
    logic           li_rise;
    logic [31:0]    li_count_q;

    assign li_rise = common_control_five_q[CTRL5_LINE_IF_RESET_BIT]
                     && !li_bit_q;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            li_bit_q <= 1'b0;
        end else begin
            li_bit_q <= common_control_five_q[CTRL5_LINE_IF_RESET_BIT];
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            li_state_q <= LI_IDLE;
            li_count_q <= 32'h0000_0000;
        end else begin
            case (li_state_q)
                LI_IDLE: begin
                    if (li_rise) begin
                        li_state_q <= LI_RECOVER;
                        li_count_q <= 32'h0000_0000;
                    end
                end
                LI_RECOVER: begin
                    if (li_rise) begin
                        li_count_q <= 32'h0000_0000;
                    end else if (li_count_q
                                 == 32'(RECOVER_CYCLES - 1)) begin
                        li_state_q <= LI_IDLE;
                    end else begin
                        li_count_q <= li_count_q + 32'h0000_0001;
                    end
                end
                default: begin
                    li_state_q <= LI_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            line_if_reset_out      <= 1'b0;
            line_if_recovering_out <= 1'b0;
        end else begin
            line_if_reset_out      <= li_rise;
            line_if_recovering_out <= li_rise
                                   || (li_state_q == LI_RECOVER
                                       && li_count_q
                                          != 32'(RECOVER_CYCLES - 1));
        end
    end

    // ==================================================================
    // latched status and information registers
    logic [7:0] sr1_view;
    logic [7:0] sr1_pend;
    logic [7:0] sr2_view;
    logic [7:0] sr2_pend;
    logic [7:0] rir_view;

    // level alarms, loss of sync among them
    status_latch #(
        .WIDTH        (8),
        .PERSIST_MASK (SR1_PERSIST_MASK),
        .CHANGE_MASK  (SR1_CHANGE_MASK)
    ) u_status_one (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .event_in   (status_one_event_in),
        .level_in   (status_one_level_in),
        .mask_wr_in (wr_sr1),
        .rd_in      (rd_sr1),
        .wdata_in   (host_req_in.wdata),
        .view_out   (sr1_view),
        .pend_out   (sr1_pend)
    );

    status_latch #(
        .WIDTH        (8),
        .PERSIST_MASK (NO_BITS_MASK),
        .CHANGE_MASK  (NO_BITS_MASK)
    ) u_status_two (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .event_in   (status_two_event_in),
        .level_in   (8'h00),
        .mask_wr_in (wr_sr2),
        .rd_in      (rd_sr2),
        .wdata_in   (host_req_in.wdata),
        .view_out   (sr2_view),
        .pend_out   (sr2_pend)
    );

    // one event input per bit
    status_latch #(
        .WIDTH        (8),
        .PERSIST_MASK (NO_BITS_MASK),
        .CHANGE_MASK  (NO_BITS_MASK)
    ) u_rx_info (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .event_in   (rx_info_event_in),
        .level_in   (8'h00),
        .mask_wr_in (wr_rir),
        .rd_in      (rd_rir),
        .wdata_in   (host_req_in.wdata),
        .view_out   (rir_view),
        .pend_out   ()
    );

    // ==================================================================
    // interrupt output
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_n_out <= 1'b1;
        end else begin
            int_n_out <= ~(|(sr1_pend & irq_mask_one_q)
                         | |(sr2_pend & irq_mask_two_q));
        end
    end

    // ==================================================================
    // crc4 multiframe search timer and sync counter
    logic [31:0]                     search_count_q;
    logic                            search_timeout;
    logic [CRC_SYNC_COUNT_WIDTH-1:0] crc_sync_count_q;
    logic                            crc_en;

    assign crc_en         = common_control_one_q[CTRL1_CRC4_EN_BIT];
    assign search_timeout = crc_en && crc_mf_searching_in
                            && search_count_q
                               == 32'(CRC_SEARCH_LENGTH - 1);

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            search_count_q <= 32'h0000_0000;
        end else if (!crc_en || !crc_mf_searching_in || search_timeout) begin
            search_count_q <= 32'h0000_0000;
        end else begin
            search_count_q <= search_count_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            crc_sync_count_q <= '0;
        end else if (!crc_en || crc_sync_achieved_in) begin
            crc_sync_count_q <= '0;
        end else if (search_timeout) begin
            crc_sync_count_q <= crc_sync_count_q + 1'b1;
        end
    end

    // ==================================================================
    // receive channel monitor capture
    logic [7:0] rx_chan_monitor_data_q;

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_chan_monitor_data_q <= MON_DATA_RESET;
        end else if (rx_chan_valid_in
                     && rx_chan_num_in
                        == common_control_five_q[CTRL5_SEL_MSB:
                                                 CTRL5_SEL_LSB]) begin
            rx_chan_monitor_data_q <= rx_chan_byte_in;
        end
    end

    // ==================================================================
    // read data
    logic [7:0] sync_status;
    logic [7:0] rd_mux;

    assign sync_status = {crc_sync_count_q[5:2], crc_sync_count_q[0],
                          frame_align_searching_in,
                          cas_mf_searching_in,
                          crc_mf_searching_in};

    always_comb begin
        case (host_req_in.addr)
            OFS_STATUS_REG_ONE:       rd_mux = sr1_view;
            OFS_STATUS_REG_TWO:       rd_mux = sr2_view;
            OFS_RECEIVE_INFORMATION:  rd_mux = rir_view;
            OFS_SYNCHRONIZER_STATUS:  rd_mux = sync_status;
            OFS_IRQ_MASK_ONE:         rd_mux = irq_mask_one_q;
            OFS_IRQ_MASK_TWO:         rd_mux = irq_mask_two_q;
            OFS_COMMON_CONTROL_ONE:   rd_mux = common_control_one_q;
            OFS_COMMON_CONTROL_FIVE:  rd_mux = common_control_five_q;
            OFS_RX_CHAN_MONITOR_DATA: rd_mux = rx_chan_monitor_data_q;
            default:                  rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (host_req_in.rd) begin
            rdata_out <= rd_mux;
        end
    end

endmodule // e1_status_latch_and_irq
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model
    import e1_status_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic [7:0] rdata_in,
    output var  host_req_t  req_out
);
    // ==================================================================
    // one-cycle strobe per access
    initial req_out = '0;
    task automatic xfer(input logic w, input logic [7:0] a, dt);
        @(negedge mclk_in);
        req_out = {w, !w, a, dt};
        @(negedge mclk_in);
        req_out = '0;
    endtask
    task automatic wr(input logic [7:0] a, dt);
        xfer(1'b1, a, dt);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] dt);
        xfer(1'b0, a, 8'h00);
        dt = rdata_in;
    endtask
    // mask write, read at once, masked write-back
    task automatic poll(input logic [7:0] a, m, output logic [7:0] dt);
        wr(a, m);
        rd(a, dt);
        wr(a, dt & m);
    endtask
endmodule // host_model
`default_nettype wire

// ==== dv/e1_status_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module e1_status_sva
    import e1_status_pkg::*;
(
    input wire logic       mclk_in,
    input wire logic       rstn_in,
    input wire host_req_t  host_req_in,
    input wire logic [7:0] rdata_out,
    input wire logic       int_n_out,
    input wire logic [7:0] status_one_level_in,
    input wire logic [7:0] status_one_event_in,
    input wire logic [7:0] status_two_event_in,
    input wire logic       frame_align_searching_in,
    input wire logic       cas_mf_searching_in,
    input wire logic       crc_mf_searching_in,
    input wire logic       line_if_reset_out,
    input wire logic       line_if_recovering_out,
    input wire logic       crc_mode_en_out,
    input wire logic [4:0] rx_chan_monitor_sel_out
);
    // ==================================================================
    // helpers
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] lvl_q;
    logic       cause;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) lvl_q <= 8'h00;
        else lvl_q <= status_one_level_in;
    end
    assign cause = |{status_one_event_in, status_two_event_in}
        || host_req_in.wr || (status_one_level_in != lvl_q);
    sequence s_wr(a);
        host_req_in.wr && host_req_in.addr == a;
    endsequence
    sequence s_rd(a);
        host_req_in.rd && host_req_in.addr == a;
    endsequence
    // ==================================================================
    // assertions
    a_pulse_cause: assert property (line_if_reset_out |->
        $past(host_req_in.wr && host_req_in.addr == 8'haa
        && host_req_in.wdata[7], 2)) else $error("reset pulse without write");
    a_pulse_shape: assert property (line_if_reset_out |=>
        !line_if_reset_out && line_if_recovering_out)
        else $error("reset pulse shape wrong");
    a_no_pulse_low: assert property (s_wr(OFS_COMMON_CONTROL_FIVE)
        ##0 !host_req_in.wdata[7] |-> ##2 !line_if_reset_out)
        else $error("reset pulse on cleared bit");
    a_sel_copy: assert property (s_wr(OFS_COMMON_CONTROL_FIVE) |-> ##2
        rx_chan_monitor_sel_out == $past(host_req_in.wdata[4:0], 2))
        else $error("monitor select not copied");
    a_crc_en_copy: assert property (s_wr(OFS_COMMON_CONTROL_ONE) |-> ##2
        crc_mode_en_out == $past(host_req_in.wdata[0], 2))
        else $error("crc enable not copied");
    a_sync_live: assert property (s_rd(OFS_SYNCHRONIZER_STATUS) |=>
        rdata_out[2:0] == $past({frame_align_searching_in,
        cas_mf_searching_in, crc_mf_searching_in}))
        else $error("sync status not live");
    a_rdata_hold: assert property (!host_req_in.rd
        |=> $stable(rdata_out)) else $error("read data moved without read");
    a_irq_cause: assert property ($fell(int_n_out) |->
        $past(cause, 2) || $past(cause, 3))
        else $error("interrupt without cause");
    a_irq_release: assert property ($rose(int_n_out) |->
        $past(host_req_in.rd || host_req_in.wr, 2)
        || $past(host_req_in.rd || host_req_in.wr, 3))
        else $error("interrupt released without access");
endmodule // e1_status_sva
bind e1_status_latch_and_irq e1_status_sva i_e1_status_sva (.*);
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import e1_status_pkg::*;
    // ==================================================================
    // stimulus and design
    logic       mclk_in = 1'b0, rstn_in = 1'b0, crc = 1'b0, fas = 1'b0;
    logic       cas = 1'b0, sync = 1'b0, ch_v = 1'b0, int_n, li_rst, li_rec;
    logic       crc_en;
    logic [7:0] lvl = 8'h00, s1_ev = 8'h00, s2_ev = 8'h00, ri_ev = 8'h00;
    logic [7:0] ch_byte = 8'h00, rdata, d, sel;
    logic [4:0] ch_num = 5'h00, sel_out;
    host_req_t  req;
    int         fails = 0, n_tests = 0, seed = 32'h970b07c7, n, k;
    initial forever #10 mclk_in = ~mclk_in;
    e1_status_latch_and_irq #(.RECOVER_CYCLES(20), .CRC_SEARCH_LENGTH(16))
    i_e1_status_latch_and_irq (.mclk_in, .rstn_in, .host_req_in(req),
        .rdata_out(rdata), .int_n_out(int_n), .status_one_level_in(lvl),
        .status_one_event_in(s1_ev), .status_two_event_in(s2_ev),
        .rx_info_event_in(ri_ev), .frame_align_searching_in(fas),
        .cas_mf_searching_in(cas), .crc_mf_searching_in(crc),
        .crc_sync_achieved_in(sync), .rx_chan_valid_in(ch_v),
        .rx_chan_num_in(ch_num), .rx_chan_byte_in(ch_byte),
        .line_if_reset_out(li_rst), .line_if_recovering_out(li_rec),
        .crc_mode_en_out(crc_en), .rx_chan_monitor_sel_out(sel_out));
    host_model i_host_model (.mclk_in, .rdata_in(rdata), .req_out(req));
    // ==================================================================
    // checking
    function automatic logic [7:0] synchronizer_status(int c, logic [2:0] s);
        return {c[5:2], c[0], s};
    endfunction
    task automatic check(logic [7:0] seen, exp, string msg);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic print_verdict;
        if (fails == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic ticks(int c);
        repeat (c) @(negedge mclk_in);
    endtask
    task automatic poll(logic [7:0] a, m, exp, string msg);
        i_host_model.poll(a, m, d);
        check(d, exp, msg);
    endtask
    task automatic sync_check(int c, string msg);
        i_host_model.rd(OFS_SYNCHRONIZER_STATUS, d);
        check(d, synchronizer_status(c, 3'b010), msg);
    endtask
    initial begin
        #500us;
        fails++;
        print_verdict;
    end
    // ==================================================================
    // main sequence
    initial begin
        ticks(6);
        rstn_in = 1'b1;
        check(int_n, 1'b1, "irq idle");
        sel = 8'($random(seed)) & 8'h1f;
        i_host_model.wr(OFS_COMMON_CONTROL_FIVE, sel);
        i_host_model.rd(OFS_COMMON_CONTROL_FIVE, d);
        check(d, sel, "ctrl5 readback");
        check(sel_out, sel[4:0], "select out");
        {ch_v, ch_num, ch_byte} = {1'b1, sel[4:0], 8'($random(seed))};
        ticks(1);
        {ch_num, ch_byte} = ~{ch_num, ch_byte};
        ticks(1);
        ch_v = 1'b0;
        i_host_model.rd(OFS_RX_CHAN_MONITOR_DATA, d);
        check(d, ~ch_byte, "monitor data");
        for (n = 0; n < 4; n++) begin
            i_host_model.wr(OFS_COMMON_CONTROL_FIVE, {n != 2, 2'b00, sel[4:0]});
            k = 0;
            repeat (3) begin
                ticks(1);
                k += li_rst;
            end
            check(8'(k), 8'(n == 0 || n == 3), "line reset pulse");
        end
        ticks(13);
        check(li_rec, 1'b1, "recovering");
        ticks(10);
        check(li_rec, 1'b0, "recovered");
        // crc4 sync counter, across its wrap
        k = 60 + ($random(seed) & 7);
        i_host_model.wr(OFS_COMMON_CONTROL_ONE, 8'h01);
        {fas, cas, crc} = 3'b101;
        ticks(k * 16 + 8);
        {fas, cas, crc} = 3'b010;
        i_host_model.wr(OFS_SYNCHRONIZER_STATUS, 8'hff);
        sync_check(k % 64, "sync count");
        sync = 1'b1;
        ticks(1);
        sync = 1'b0;
        sync_check(0, "sync clear");
        crc = 1'b1;
        ticks(24);
        crc = 1'b0;
        sync_check(1, "sync one");
        i_host_model.wr(OFS_COMMON_CONTROL_ONE, 8'h00);
        sync_check(0, "disable clear");
        // info latching and mask
        for (n = 0; n < 8; n++) begin
            ri_ev = 8'h01 << n;
            ticks(1);
            ri_ev = 8'h00;
            poll(OFS_RECEIVE_INFORMATION, 8'hff, 8'h01 << n, "info set");
            poll(OFS_RECEIVE_INFORMATION, 8'hff, 8'h00, "info clear");
        end
        ri_ev = 8'h81;
        ticks(1);
        ri_ev = 8'h00;
        poll(OFS_RECEIVE_INFORMATION, 8'h01, 8'h01, "mask low");
        poll(OFS_RECEIVE_INFORMATION, 8'h80, 8'h80, "mask held");
        // alarm change irq
        i_host_model.wr(OFS_IRQ_MASK_ONE, 8'h02);
        for (n = 0; n < 2; n++) begin
            lvl = n ? 8'h00 : 8'he3;
            ticks(4);
            check(int_n, 1'b0, "alarm change irq");
            poll(OFS_STATUS_REG_ONE, 8'hff, 8'he3, "alarm latched");
            ticks(2);
            check(int_n, 1'b1, "alarm irq release");
        end
        poll(OFS_STATUS_REG_ONE, 8'hff, 8'h00, "alarm gone");
        // event irq, masked then enabled
        for (n = 0; n < 2; n++) begin
            i_host_model.wr(OFS_IRQ_MASK_TWO, n ? 8'hff : 8'h00);
            {s1_ev, s2_ev} = {8'h10, 8'h01 << ($random(seed) & 7)};
            ticks(1);
            d = s2_ev;
            {s1_ev, s2_ev} = 16'h0000;
            ticks(3);
            check(int_n, 1'(!n), "event irq");
            poll(OFS_STATUS_REG_TWO, 8'hff, d, "event latched");
            poll(OFS_STATUS_REG_ONE, 8'hff, 8'h10, "slip latched");
            ticks(2);
            check(int_n, 1'b1, "event irq release");
        end
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
